// [core/scp_top.sv]
// control-input logic of a two-phase stepper driver
module scp_top
  import scp_pkg::*;
#(
  parameter int SLEEP_CYCLES = SLEEP_WIDTH_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic serial_clk_in,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic ms_in,
  input wire logic serial_mode_in,
  input wire logic fault_clear_n_in,
  input wire logic overcurrent_in,
  input wire logic fault_in,
  output logic [POS_W-1:0] position_out,
  output logic [WORD_W-1:0] word_out,
  output logic word_valid_out,
  output logic word_error_out,
  output logic quarter_step_out,
  output logic outputs_enable_out,
  output logic current_limit_out,
  output logic sleep_out,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe_out
);
  typedef enum logic [1:0] {FR_IDLE, FR_ACTIVE, FR_SETTLE} scp_frame_e;

  scp_pins_s pins_raw;
  scp_pins_s meta_q, sync_q, prev_q;
  logic [EDGE_CNT_W-1:0] gray_meta_q, gray_sync_q;
  logic [EDGE_CNT_W-1:0] rx_gray;
  logic [WORD_W-1:0] rx_word;
  logic [EDGE_CNT_W-1:0] edge_cnt;
  logic step_rise;

  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic quarter_q, quarter_d;
  logic [POS_W-1:0] pos_q, pos_d;
  logic [POS_W-1:0] inc;

  scp_frame_e fr_q, fr_d;
  logic [EDGE_CNT_W-1:0] start_cnt_q, start_cnt_d;
  logic [1:0] settle_q, settle_d;
  logic [WORD_W-1:0] word_q, word_d;
  logic word_valid_q, word_valid_d;
  logic word_error_q, word_error_d;

  logic f_sleep, f_short, f_limit, f_fault;
  logic oe_q, oe_d;
  logic limit_q;
  logic sleep_q;
  logic flag_oe_q, flag_oe_d;

  // gather the pin levels into one carrier
  always_comb begin
    pins_raw.step = step_in;
    pins_raw.dir = dir_in;
    pins_raw.ms = ms_in;
    pins_raw.serial_mode = serial_mode_in;
    pins_raw.clear_n = fault_clear_n_in;
    pins_raw.overcurrent = overcurrent_in;
    pins_raw.fault = fault_in;
  end

  // two-flop synchronisers for pins and the serial edge count
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= PINS_RST;
      sync_q <= PINS_RST;
      prev_q <= PINS_RST;
      gray_meta_q <= '0;
      gray_sync_q <= '0;
    end else if (ce_in) begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
      gray_meta_q <= rx_gray;
      gray_sync_q <= gray_meta_q;
    end
  end

  // serial shifter on the link clock
  scp_serial_rx u_rx (
    .serial_clk_in(serial_clk_in),
    .rst_n_in(rst_n_in),
    .serial_strobe_n_in(step_in),
    .serial_data_in(dir_in),
    .word_out(rx_word),
    .edge_gray_out(rx_gray)
  );

  // gray to binary for the synchronised edge count
  always_comb begin
    edge_cnt[EDGE_CNT_W-1] = gray_sync_q[EDGE_CNT_W-1];
    for (int i = EDGE_CNT_W - 2; i >= 0; i--) begin
      edge_cnt[i] = edge_cnt[i+1] ^ gray_sync_q[i];
    end
  end

  // only a rising edge of the step pin counts
  assign step_rise = sync_q.step & ~prev_q.step;

  // microstep strap caught once the synchroniser holds the real pin level
  always_comb begin
    strap_cnt_d = strap_cnt_q;
    quarter_d = quarter_q;
    // the first two enabled edges still see the reset value of the sync flops
    if (strap_cnt_q != 2'h3) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      quarter_d = sync_q.ms;
    end
    inc = quarter_q ? INC_QUARTER : INC_HALF;
  end

  // position counter, wraps over the 64-step electrical cycle
  always_comb begin
    pos_d = pos_q;
    if (!sync_q.serial_mode && step_rise) begin
      // direction is read only here, so a change waits for the next edge
      if (sync_q.dir) begin
        pos_d = pos_q + inc;
      end else begin
        pos_d = pos_q - inc;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      strap_cnt_q <= 2'h0;
      quarter_q <= 1'b0;
      pos_q <= POS_HOME;
    end else if (ce_in) begin
      strap_cnt_q <= strap_cnt_d;
      quarter_q <= quarter_d;
      pos_q <= pos_d;
    end
  end

  // frame tracker: counts edges between strobe fall and rise
  always_comb begin
    fr_d = fr_q;
    start_cnt_d = start_cnt_q;
    settle_d = settle_q;
    word_d = word_q;
    word_valid_d = 1'b0;
    word_error_d = 1'b0;
    case (fr_q)
      FR_IDLE: begin
        // strobe low opens a frame, only in serial mode
        if (sync_q.serial_mode && !sync_q.step) begin
          start_cnt_d = edge_cnt;
          fr_d = FR_ACTIVE;
        end
      end
      FR_ACTIVE: begin
        if (sync_q.step) begin
          settle_d = SETTLE_CYC;
          fr_d = FR_SETTLE;
        end
      end
      FR_SETTLE: begin
        // wait for the gray count to catch up with the strobe
        if (settle_q != 2'h0) begin
          settle_d = settle_q - 2'h1;
        end else begin
          fr_d = FR_IDLE;
          // shifter is quiet while the strobe is high, so the word is stable
          if (edge_cnt - start_cnt_q == EDGES_PER_WORD) begin
            word_d = rx_word;
            word_valid_d = 1'b1;
          end else begin
            word_error_d = 1'b1;
          end
        end
      end
      default: fr_d = FR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fr_q <= FR_IDLE;
      start_cnt_q <= '0;
      settle_q <= '0;
      word_q <= WORD_RST;
      word_valid_q <= 1'b0;
      word_error_q <= 1'b0;
    end else if (ce_in) begin
      fr_q <= fr_d;
      start_cnt_q <= start_cnt_d;
      settle_q <= settle_d;
      word_q <= word_d;
      word_valid_q <= word_valid_d;
      word_error_q <= word_error_d;
    end
  end

  // fault latch, sleep timer and overcurrent delay
  scp_fault_ctl #(
    .SLEEP_CYCLES(SLEEP_CYCLES),
    .OC_CYCLES(OC_DELAY_CYC)
  ) u_fault (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .clear_n_in(sync_q.clear_n),
    .overcurrent_in(sync_q.overcurrent),
    .fault_in(sync_q.fault),
    .sleep_out(f_sleep),
    .short_out(f_short),
    .limit_out(f_limit),
    .fault_out(f_fault)
  );

  // bridge enable off in sleep or after a confirmed short
  always_comb begin
    oe_d = ~f_sleep & ~f_short;
    flag_oe_d = f_fault;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      oe_q <= 1'b0;
      limit_q <= 1'b0;
      sleep_q <= 1'b0;
      flag_oe_q <= 1'b0;
    end else if (ce_in) begin
      oe_q <= oe_d;
      limit_q <= f_limit;
      sleep_q <= f_sleep;
      flag_oe_q <= flag_oe_d;
    end
  end

  assign position_out = pos_q;
  assign word_out = word_q;
  assign word_valid_out = word_valid_q;
  assign word_error_out = word_error_q;
  assign quarter_step_out = quarter_q;
  assign outputs_enable_out = oe_q;
  assign current_limit_out = limit_q;
  assign sleep_out = sleep_q;
  // open drain: the driven level is always low, only the enable moves
  assign fault_flag_n_out = 1'b0;
  assign fault_flag_n_oe_out = flag_oe_q;
endmodule // scp_top

// [core/scp_pkg.sv]
// shared constants and carrier types for the stepper control port
package scp_pkg;
  // system clock rate
  localparam int CLK_MHZ = 250;
  // overcurrent fault delay, least time, rounded up to cycles
  localparam int OC_DELAY_NS = 2000;
  localparam int OC_DELAY_CYC = (OC_DELAY_NS * CLK_MHZ + 999) / 1000;
  // sleep entry width, least low time of the clear pin
  localparam int SLEEP_WIDTH_US = 40;
  localparam int SLEEP_WIDTH_CYC = SLEEP_WIDTH_US * CLK_MHZ;
  // electrical position in sixteenth microsteps, 64 per cycle
  localparam int POS_W = 6;
  localparam logic [5:0] POS_HOME = 6'h08;
  localparam logic [5:0] INC_HALF = 6'h08;
  localparam logic [5:0] INC_QUARTER = 6'h04;
  // serial word
  localparam int WORD_W = 16;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam int EDGE_CNT_W = 8;
  localparam logic [7:0] EDGES_PER_WORD = 8'h10;
  // cycles to wait after strobe release before the word is read
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // raw pin levels, sampled together
  typedef struct packed {
    logic step;
    logic dir;
    logic ms;
    logic serial_mode;
    logic clear_n;
    logic overcurrent;
    logic fault;
  } scp_pins_s;

  localparam scp_pins_s PINS_RST = '{step: 1'b0, dir: 1'b0, ms: 1'b0, serial_mode: 1'b0,
                                     clear_n: 1'b1, overcurrent: 1'b0, fault: 1'b0};
endpackage

// [core/scp_serial_rx.sv]
// serial shifter running on the serial clock pin
module scp_serial_rx
  import scp_pkg::*;
(
  input wire logic serial_clk_in,
  input wire logic rst_n_in,
  input wire logic serial_strobe_n_in,
  input wire logic serial_data_in,
  output logic [WORD_W-1:0] word_out,
  output logic [EDGE_CNT_W-1:0] edge_gray_out
);
  logic [WORD_W-1:0] word_q, word_d;
  logic [EDGE_CNT_W-1:0] cnt_q, cnt_d;
  logic [EDGE_CNT_W-1:0] gray_q, gray_d;

  // shift msb first and count edges only while the strobe is low
  always_comb begin
    word_d = word_q;
    cnt_d = cnt_q;
    if (!serial_strobe_n_in) begin
      word_d = {word_q[WORD_W-2:0], serial_data_in};
      cnt_d = cnt_q + 8'h01;
    end
    // gray code so the system side can sample the count safely
    gray_d = cnt_d ^ (cnt_d >> 1);
  end

  // the serial clock need not run while reset is held, so reset acts without it
  always_ff @(posedge serial_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_q <= WORD_RST;
      cnt_q <= '0;
      gray_q <= '0;
    end else begin
      word_q <= word_d;
      cnt_q <= cnt_d;
      gray_q <= gray_d;
    end
  end

  assign word_out = word_q;
  assign edge_gray_out = gray_q;
endmodule // scp_serial_rx

// [core/scp_fault_ctl.sv]
// fault latch, clear pulse, sleep entry and overcurrent delay
module scp_fault_ctl
  import scp_pkg::*;
#(
  parameter int SLEEP_CYCLES = SLEEP_WIDTH_CYC,
  parameter int OC_CYCLES = OC_DELAY_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic clear_n_in,
  input wire logic overcurrent_in,
  input wire logic fault_in,
  output logic sleep_out,
  output logic short_out,
  output logic limit_out,
  output logic fault_out
);
  logic [15:0] low_cnt_q, low_cnt_d;
  logic [15:0] oc_cnt_q, oc_cnt_d;
  logic sleep_q, sleep_d;
  logic short_q, short_d;
  logic limit_q, limit_d;
  logic fault_q, fault_d;

  always_comb begin
    low_cnt_d = low_cnt_q;
    oc_cnt_d = oc_cnt_q;
    sleep_d = sleep_q;
    short_d = short_q;
    limit_d = 1'b0;
    // measure how long the clear pin stays low
    if (!clear_n_in) begin
      if (low_cnt_q != 16'hffff) low_cnt_d = low_cnt_q + 16'h0001;
      if (low_cnt_q >= 16'(SLEEP_CYCLES)) sleep_d = 1'b1;
    end else begin
      low_cnt_d = '0;
      sleep_d = 1'b0;
      // a short low pulse clears the latch on release
      if (low_cnt_q != 16'h0000) short_d = 1'b0;
    end
    // limit current during the delay, flag only if it lasts beyond it
    if (overcurrent_in) begin
      if (oc_cnt_q < 16'(OC_CYCLES)) begin
        oc_cnt_d = oc_cnt_q + 16'h0001;
        limit_d = 1'b1;
      end else begin
        short_d = 1'b1; // set wins over a clear in the same cycle
      end
    end else begin
      oc_cnt_d = '0;
    end
    fault_d = short_d | fault_in;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      low_cnt_q <= '0;
      oc_cnt_q <= '0;
      sleep_q <= 1'b0;
      short_q <= 1'b0;
      limit_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (ce_in) begin
      low_cnt_q <= low_cnt_d;
      oc_cnt_q <= oc_cnt_d;
      sleep_q <= sleep_d;
      short_q <= short_d;
      limit_q <= limit_d;
      fault_q <= fault_d;
    end
  end

  assign sleep_out = sleep_q;
  assign short_out = short_q;
  assign limit_out = limit_q;
  assign fault_out = fault_q;
endmodule // scp_fault_ctl

// [dv/scp_top_chk.sv]
// assertions on the pins of the stepper control port
module scp_top_chk
  import scp_pkg::*;
#(
  parameter int SLEEP_CYCLES = SLEEP_WIDTH_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic step_in,
  input wire logic serial_mode_in,
  input wire logic fault_clear_n_in,
  input wire logic overcurrent_in,
  input wire logic fault_in,
  input wire logic [POS_W-1:0] position_out,
  input wire logic [WORD_W-1:0] word_out,
  input wire logic word_valid_out,
  input wire logic word_error_out,
  input wire logic quarter_step_out,
  input wire logic outputs_enable_out,
  input wire logic current_limit_out,
  input wire logic sleep_out,
  input wire logic fault_flag_n_out,
  input wire logic fault_flag_n_oe_out
);
  int low_q, low_d, oc_q, oc_d;
  logic [5:0] inc_w;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  assign inc_w = quarter_step_out ? INC_QUARTER : INC_HALF;
  // raw run lengths; saturate so a long run never wraps
  always_comb begin
    low_d = fault_clear_n_in ? 0 : (low_q < 99999 ? low_q + 1 : low_q);
    oc_d = !overcurrent_in ? 0 : (oc_q < 9999 ? oc_q + 1 : oc_q);
  end
  always_ff @(posedge clk_in) begin
    low_q <= rst_n_in ? low_d : 0;
    oc_q <= rst_n_in ? oc_d : 0;
  end
  AST_POS_QUIET: assert property ($stable(step_in)[*6] |=> $stable(position_out))
    else $error("position moved without a step edge");
  AST_POS_INC: assert property (!$stable(position_out) |-> (6'(position_out - $past(position_out)) == inc_w)
    || (6'($past(position_out) - position_out) == inc_w)) else $error("position moved by a wrong amount");
  AST_POS_HOME: assert property ($rose(rst_n_in) |-> position_out == POS_HOME)
    else $error("position not home after reset");
  AST_WORD_HOLD: assert property (!$stable(word_out) |-> word_valid_out)
    else $error("word changed without valid");
  AST_PULSE: assert property (word_valid_out || word_error_out |=> !word_valid_out && !word_error_out)
    else $error("word pulse too long");
  AST_STROBE: assert property (word_valid_out || word_error_out |-> $past(step_in, 5) && serial_mode_in)
    else $error("word pulse without strobe release");
  AST_SLEEP_MIN: assert property ($rose(sleep_out) |-> low_q >= SLEEP_CYCLES)
    else $error("sleep entered too early");
  AST_SLEEP_MAX: assert property (low_q == SLEEP_CYCLES + 8 |-> sleep_out)
    else $error("sleep not entered");
  AST_SLEEP_OFF: assert property (sleep_out |-> !outputs_enable_out)
    else $error("outputs on in sleep");
  AST_OC_LIMIT: assert property (oc_q inside {[4:OC_DELAY_CYC - 4]} && !sleep_out |-> current_limit_out)
    else $error("no current limit during delay");
  AST_OC_SHORT: assert property (oc_q == OC_DELAY_CYC + 8 |-> !outputs_enable_out)
    else $error("short not flagged after delay");
  AST_FLAG: assert property ($rose(fault_in) |-> ##[1:6] fault_flag_n_oe_out && !fault_flag_n_out)
    else $error("fault flag not pulled low");
endmodule // scp_top_chk

bind scp_top scp_top_chk #(.SLEEP_CYCLES(SLEEP_CYCLES)) i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .step_in(step_in), .serial_mode_in(serial_mode_in), .fault_clear_n_in(fault_clear_n_in),
  .overcurrent_in(overcurrent_in), .fault_in(fault_in), .position_out(position_out), .word_out(word_out),
  .word_valid_out(word_valid_out), .word_error_out(word_error_out), .quarter_step_out(quarter_step_out),
  .outputs_enable_out(outputs_enable_out), .current_limit_out(current_limit_out), .sleep_out(sleep_out),
  .fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe_out(fault_flag_n_oe_out));

// [dv/scp_host.sv]
// host model driving the step, direction and serial clock pins
module scp_host (
  input wire logic clk_in,
  output logic step_out,
  output logic dir_out,
  output logic sck_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins start low, as the pull-downs leave them
  initial begin
    step_out = 1'b0;
    dir_out = 1'b0;
    sck_out = 1'b0;
  end
  // one step, direction settled three cycles before the rise
  task automatic pulse(input logic d);
    dir_out = d;
    repeat (3) @(posedge clk_in);
    #1 step_out = 1'b1;
    repeat (2) @(posedge clk_in);
    // a direction change after the rise must wait for the next step
    #1 dir_out = ~d;
    repeat (2) @(posedge clk_in);
    #1 step_out = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  // one strobe frame of n clock rises, 6 ns serial clock
  task automatic frame(input logic [15:0] w, input int n);
    @(posedge clk_in);
    #1 step_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      #3 sck_out = 1'b0;
      dir_out = w[15 - i % 16];
      #3 sck_out = 1'b1;
    end
    repeat (2) @(posedge clk_in);
    #1 step_out = 1'b1;
    dir_out = 1'b0; // released line falls to its pull-down
  endtask
  // clock and data toggling while the strobe is high
  task automatic noise();
    repeat (5) begin
      #3 sck_out = 1'b0;
      dir_out = ~dir_out;
      #3 sck_out = 1'b1;
    end
  endtask
endmodule // scp_host

// [dv/test_stepper_control_port.sv]
// self-checking bench for the stepper control port
module test_stepper_control_port
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SLP = 20;
  logic clk_in, rst_n_in, ce_in, serial_mode_in, fault_clear_n_in, overcurrent_in, fault_in;
  logic [5:0] position_out;
  logic [15:0] word_out, w;
  logic [15:0] wq [$];
  logic word_valid_out, word_error_out, quarter_step_out, outputs_enable_out, current_limit_out;
  logic sleep_out, fault_flag_n_out, fault_flag_n_oe_out, step, dir, sck, d;
  int fails, n_tests, seed, pos, i, k;
  int ne [5] = '{16, 15, 16, 17, 16};
  // 250 MHz system clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  scp_host i_host (.clk_in(clk_in), .step_out(step), .dir_out(dir), .sck_out(sck));
  // serial clock and microstep select share one pin
  scp_top #(.SLEEP_CYCLES(SLP)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .serial_clk_in(sck), .step_in(step), .dir_in(dir), .ms_in(sck), .serial_mode_in(serial_mode_in),
    .fault_clear_n_in(fault_clear_n_in), .overcurrent_in(overcurrent_in), .fault_in(fault_in),
    .position_out(position_out), .word_out(word_out), .word_valid_out(word_valid_out),
    .word_error_out(word_error_out), .quarter_step_out(quarter_step_out), .outputs_enable_out(outputs_enable_out),
    .current_limit_out(current_limit_out), .sleep_out(sleep_out), .fault_flag_n_out(fault_flag_n_out),
    .fault_flag_n_oe_out(fault_flag_n_oe_out));
  task automatic end_sim();
    $display("checks %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk_bit(input string s, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic chk_pos(input logic [5:0] g, input logic [5:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD position exp %h got %h", e, g);
    end
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD word exp %h got %h", e, g);
    end
  endtask
  // inputs move 1 ns after the edge, outputs read there too
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // microstep strap held on the shared pin through reset
  task automatic do_reset(input logic ms);
    rst_n_in = 1'b0;
    i_host.sck_out = ms;
    cyc(10);
    rst_n_in = 1'b1;
    cyc(6);
    pos = 8;
    chk_pos(position_out, 6'(pos));
    chk_bit("quarter", ms, quarter_step_out);
  endtask
  // random directions against a modulo 64 position model
  task automatic steps(input int inc);
    for (k = 0; k < 10; k++) begin
      d = 1'($random(seed));
      i_host.pulse(d);
      pos = (pos + (d ? inc : 64 - inc)) % 64;
      chk_pos(position_out, 6'(pos));
    end
  endtask
  task automatic wait_pulse(input logic ok);
    for (k = 0; k < 20; k++) begin
      cyc(1);
      if (word_valid_out === 1'b1 || word_error_out === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      end_sim();
    end
    chk_bit("valid", ok, word_valid_out);
    chk_bit("error", !ok, word_error_out);
  endtask
  initial begin
    seed = 95;
    fails = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    serial_mode_in = 1'b0;
    ce_in = 1'b1;
    fault_clear_n_in = 1'b1;
    overcurrent_in = 1'b0;
    fault_in = 1'b0;
    cyc(1);
    do_reset(1'b0);
    steps(int'(INC_HALF));
    do_reset(1'b1);
    steps(int'(INC_QUARTER));
    // clock enable low freezes the synchronisers, so a whole pulse is missed
    ce_in = 1'b0;
    i_host.pulse(1'b1);
    ce_in = 1'b1;
    cyc(4);
    chk_pos(position_out, 6'(pos));
    // serial mode: strobe rise must not step
    serial_mode_in = 1'b1;
    cyc(4);
    i_host.step_out = 1'b1;
    cyc(12);
    chk_pos(position_out, 6'(pos));
    wq.push_back(WORD_RST);
    for (i = 0; i < 5; i++) begin
      w = 16'($random(seed));
      i_host.noise();
      i_host.frame(w, ne[i]);
      wait_pulse(ne[i] == 16);
      if (ne[i] == 16) wq.push_back(w);
      chk_word(word_out, wq[$]);
      cyc(10);
    end
    // overcurrent shorter than the delay only limits
    overcurrent_in = 1'b1;
    cyc(100);
    chk_bit("limit", 1'b1, current_limit_out);
    chk_bit("enable", 1'b1, outputs_enable_out);
    overcurrent_in = 1'b0;
    cyc(10);
    chk_bit("flag", 1'b0, fault_flag_n_oe_out);
    overcurrent_in = 1'b1;
    cyc(520);
    overcurrent_in = 1'b0;
    cyc(10);
    chk_bit("enable", 1'b0, outputs_enable_out);
    chk_bit("flag", 1'b1, fault_flag_n_oe_out);
    fault_clear_n_in = 1'b0;
    cyc(5);
    fault_clear_n_in = 1'b1;
    cyc(6);
    chk_bit("flag", 1'b0, fault_flag_n_oe_out);
    chk_bit("sleep", 1'b0, sleep_out);
    fault_in = 1'b1;
    cyc(6);
    chk_bit("flag", 1'b1, fault_flag_n_oe_out);
    fault_in = 1'b0;
    fault_clear_n_in = 1'b0;
    cyc(SLP + 10);
    chk_bit("sleep", 1'b1, sleep_out);
    chk_bit("enable", 1'b0, outputs_enable_out);
    fault_clear_n_in = 1'b1;
    cyc(8);
    chk_bit("enable", 1'b1, outputs_enable_out);
    end_sim();
  end
endmodule // test_stepper_control_port
